// ### design/lcd_cfg_pkg.sv
package lcd_cfg_pkg;

	// Drive geometry.
	localparam int SEG_COUNT = 132;
	localparam int COM_COUNT = 49;
	localparam int MUX_COUNT = 181;
	localparam int SCAN_LINES = 48;
	localparam logic [5:0] LINE_FIRST = 6'h00;
	localparam logic [5:0] LINE_LAST = 6'h2f;
	localparam logic [5:0] LINE_INDICATOR = 6'h30;

	// Command bytes; the mask keeps the opcode part of the byte.
	localparam logic [7:0] MASK_LSB = 8'hfe;
	localparam logic [7:0] MASK_LOW3 = 8'hf8;
	localparam logic [7:0] MASK_DIR = 8'hf7;
	localparam logic [7:0] CMD_DISPLAY = 8'hae;
	localparam logic [7:0] CMD_REVERSE = 8'ha6;
	localparam logic [7:0] CMD_ALL_ON = 8'ha4;
	localparam logic [7:0] CMD_BIAS = 8'ha2;
	localparam logic [7:0] CMD_COM_DIR = 8'hc0;
	localparam logic [7:0] CMD_INDICATOR = 8'hac;
	localparam logic [7:0] CMD_POWER = 8'h28;
	localparam logic [7:0] CMD_GAIN = 8'h20;
	localparam logic [7:0] CMD_CONTRAST = 8'h81;
	localparam int DIR_BIT = 3;

	// Register fields and reset values.
	localparam logic [5:0] CONTRAST_MAX = 6'h3f;
	localparam logic [5:0] CONTRAST_RESET = 6'h20;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [2:0] GAIN_UNUSED = 3'h7;
	localparam logic [2:0] POWER_RESET = 3'h0;
	localparam logic [2:0] POWER_ALL_ON = 3'h7;

	// Blank time after power-up by command.
	localparam int POWER_WAIT_MS = 300;
	localparam int CLK_HZ = 100_000_000;
	localparam int POWER_WAIT_CYCLES = POWER_WAIT_MS * (CLK_HZ / 1000);

	// Two-bit drive level code: {selected, polarity}.
	localparam logic [1:0] LEVEL_RESET = 2'h0;

	typedef enum logic [1:0] {
		PEND_NONE,
		PEND_CONTRAST,
		PEND_INDICATOR
	} pend_e;

	typedef struct packed {
		logic multiplier;
		logic adjuster;
		logic follower;
	} power_en_s;

endpackage

// ### design/drive_level_mux.sv
`timescale 1ns/1ps
`default_nettype none

module drive_level_mux #(
	parameter int SEGS = lcd_cfg_pkg::SEG_COUNT,
	parameter int COMS = lcd_cfg_pkg::COM_COUNT
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [SEGS-1:0] seg_bits,
	input wire logic [5:0] line,
	input wire logic polarity,
	output logic [2*(SEGS+COMS)-1:0] levels
);

	typedef struct packed {
		logic [2*(SEGS+COMS)-1:0] lv;
	} mux_state_s;

	mux_state_s st_reg;
	mux_state_s st_next;

	// One multiplexer per output: segment from its bit, common from scan.
	always_comb
	begin
		st_next = st_reg;
		for (int i = 0; i < SEGS; i++)
		begin
			st_next.lv[2*i +: 2] = {seg_bits[i], polarity};
		end
		for (int j = 0; j < COMS; j++)
		begin
			st_next.lv[2*(SEGS+j) +: 2] = {(line == 6'(j)), polarity};
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign levels = st_reg.lv;

endmodule

`default_nettype wire

// ### design/lcd_drive_power_config.sv
`timescale 1ns/1ps
`default_nettype none

module lcd_drive_power_config #(
	parameter int WAIT_CYCLES = lcd_cfg_pkg::POWER_WAIT_CYCLES
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CMD_WRITE,
	input wire logic [7:0] CMD_DATA,
	input wire logic LINE_TICK,
	input wire logic [lcd_cfg_pkg::SEG_COUNT-1:0] SEG_DATA,
	input wire logic INTERNAL_DIVIDER_SELECT,
	output lcd_cfg_pkg::power_en_s POWER_ENABLE,
	output logic [5:0] CONTRAST_CODE,
	output logic [5:0] ATTENUATION_STEP,
	output logic [2:0] GAIN_RATIO_CODE,
	output logic BIAS_SIXTH,
	output logic EXTERNAL_FEEDBACK_ACTIVE,
	output logic DISPLAY_ACTIVE,
	output logic [5:0] COMMON_LINE,
	output logic POLARITY_TOGGLE,
	output logic INDICATOR_COUNTER_ELECTRODE,
	output logic [2*lcd_cfg_pkg::MUX_COUNT-1:0] DRIVE_LEVELS
);

	typedef struct packed {
		lcd_cfg_pkg::pend_e pend;
		lcd_cfg_pkg::power_en_s power;
		logic [5:0] contrast;
		logic [5:0] atten;
		logic [2:0] gain;
		logic bias_sixth;
		logic display_on;
		logic reverse;
		logic all_on;
		logic com_reverse;
		logic indicator_on;
		logic fr;
		logic indicator_electrode;
		logic [5:0] line;
		logic [31:0] wait_cnt;
		logic ext_fb;
		logic active;
	} cfg_state_s;

	cfg_state_s st_reg;
	cfg_state_s st_next;
	logic [7:0] opc_lsb;
	logic [7:0] opc_low3;
	logic [7:0] opc_dir;
	logic save_now;
	logic save_next;
	logic [lcd_cfg_pkg::SEG_COUNT-1:0] seg_bits;

	// Opcode views of the incoming byte.
	assign opc_lsb = CMD_DATA & lcd_cfg_pkg::MASK_LSB;
	assign opc_low3 = CMD_DATA & lcd_cfg_pkg::MASK_LOW3;
	assign opc_dir = CMD_DATA & lcd_cfg_pkg::MASK_DIR;

	// Power save is display off together with all dots on.
	assign save_now = !st_reg.display_on && st_reg.all_on;

	// Blanked, all-on or reversed data feeds the segment multiplexers.
	always_comb
	begin
		seg_bits = '0;
		if (st_reg.active)
		begin
			if (st_reg.all_on)
				seg_bits = '1;
			else
				seg_bits = SEG_DATA ^ {lcd_cfg_pkg::SEG_COUNT{st_reg.reverse}};
		end
	end

	always_comb
	begin
		st_next = st_reg;

		// Command decode; every write lands on the accepting edge.
		if (CMD_WRITE)
		begin
			st_next.pend = lcd_cfg_pkg::PEND_NONE;
			if (st_reg.pend == lcd_cfg_pkg::PEND_CONTRAST)
			begin
				// Contrast is held whatever divider is in use.
				st_next.contrast = CMD_DATA[5:0];
			end
			else if (st_reg.pend == lcd_cfg_pkg::PEND_INDICATOR)
			begin
				// Mode byte is swallowed so it cannot decode as a command.
				st_next.pend = lcd_cfg_pkg::PEND_NONE;
			end
			else if (opc_lsb == lcd_cfg_pkg::CMD_DISPLAY)
				st_next.display_on = CMD_DATA[0];
			else if (opc_lsb == lcd_cfg_pkg::CMD_REVERSE)
				st_next.reverse = CMD_DATA[0];
			else if (opc_lsb == lcd_cfg_pkg::CMD_ALL_ON)
				st_next.all_on = CMD_DATA[0];
			else if (opc_lsb == lcd_cfg_pkg::CMD_BIAS)
				st_next.bias_sixth = CMD_DATA[0];
			else if (opc_lsb == lcd_cfg_pkg::CMD_INDICATOR)
			begin
				st_next.indicator_on = CMD_DATA[0];
				st_next.pend = lcd_cfg_pkg::PEND_INDICATOR;
			end
			else if (opc_dir == lcd_cfg_pkg::CMD_COM_DIR)
				st_next.com_reverse = CMD_DATA[lcd_cfg_pkg::DIR_BIT];
			else if (opc_low3 == lcd_cfg_pkg::CMD_POWER)
				st_next.power = CMD_DATA[2:0];
			else if (opc_low3 == lcd_cfg_pkg::CMD_GAIN)
			begin
				// The eighth code has no ratio, so it is not taken.
				if (CMD_DATA[2:0] != lcd_cfg_pkg::GAIN_UNUSED)
					st_next.gain = CMD_DATA[2:0];
			end
			else if (CMD_DATA == lcd_cfg_pkg::CMD_CONTRAST)
				st_next.pend = lcd_cfg_pkg::PEND_CONTRAST;
		end

		// Attenuation step mirrors the new code one cycle later.
		st_next.atten = lcd_cfg_pkg::CONTRAST_MAX - st_reg.contrast;

		// Blank window restarts on full power-up or leaving power save.
		save_next = !st_next.display_on && st_next.all_on;
		if ((CMD_WRITE && (st_reg.pend == lcd_cfg_pkg::PEND_NONE)
			&& (opc_low3 == lcd_cfg_pkg::CMD_POWER)
			&& (CMD_DATA[2:0] == lcd_cfg_pkg::POWER_ALL_ON))
			|| (save_now && !save_next))
			st_next.wait_cnt = 32'(WAIT_CYCLES);
		else if (st_reg.wait_cnt != 32'h0)
			st_next.wait_cnt = st_reg.wait_cnt - 32'h1;

		// Display on is remembered but held off during the wait.
		st_next.active = st_reg.display_on && (st_reg.wait_cnt == 32'h0)
			&& !save_now;

		// Common scan with the indicator common as last slot.
		if (LINE_TICK)
		begin
			if (st_reg.line == lcd_cfg_pkg::LINE_INDICATOR)
			begin
				st_next.fr = !st_reg.fr;
				st_next.line = st_reg.com_reverse ? lcd_cfg_pkg::LINE_LAST
					: lcd_cfg_pkg::LINE_FIRST;
			end
			else if (!st_reg.com_reverse)
				st_next.line = (st_reg.line == lcd_cfg_pkg::LINE_LAST)
					? lcd_cfg_pkg::LINE_INDICATOR
					: st_reg.line + 6'h1;
			else
				st_next.line = (st_reg.line == lcd_cfg_pkg::LINE_FIRST)
					? lcd_cfg_pkg::LINE_INDICATOR
					: st_reg.line - 6'h1;
		end

		// Counter electrode opposes the toggle only while lit.
		st_next.indicator_electrode = st_next.fr ^ st_reg.indicator_on;

		// Feedback pin is meaningful only without the internal divider.
		st_next.ext_fb = !INTERNAL_DIVIDER_SELECT;
	end

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			st_reg <= '0;
			st_reg.contrast <= lcd_cfg_pkg::CONTRAST_RESET;
			st_reg.atten <= lcd_cfg_pkg::CONTRAST_MAX - lcd_cfg_pkg::CONTRAST_RESET;
			st_reg.gain <= lcd_cfg_pkg::GAIN_RESET;
			st_reg.power <= lcd_cfg_pkg::POWER_RESET;
			st_reg.pend <= lcd_cfg_pkg::PEND_NONE;
		end
		else
			st_reg <= st_next;
	end

	// Level multiplexers, registered inside.
	drive_level_mux #(
		.SEGS(lcd_cfg_pkg::SEG_COUNT),
		.COMS(lcd_cfg_pkg::COM_COUNT)
	) u_mux (
		.clk(MCLK),
		.rstn(RSTN),
		.seg_bits(seg_bits),
		.line(st_reg.line),
		.polarity(st_reg.fr),
		.levels(DRIVE_LEVELS)
	);

	// All outputs are register bits.
	assign POWER_ENABLE = st_reg.power;
	assign CONTRAST_CODE = st_reg.contrast;
	assign ATTENUATION_STEP = st_reg.atten;
	assign GAIN_RATIO_CODE = st_reg.gain;
	assign BIAS_SIXTH = st_reg.bias_sixth;
	assign EXTERNAL_FEEDBACK_ACTIVE = st_reg.ext_fb;
	assign DISPLAY_ACTIVE = st_reg.active;
	assign COMMON_LINE = st_reg.line;
	assign POLARITY_TOGGLE = st_reg.fr;
	assign INDICATOR_COUNTER_ELECTRODE = st_reg.indicator_electrode;

endmodule

`default_nettype wire

// ### verif/lcd_cfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_cfg_chk (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CMD_WRITE,
	input wire logic [7:0] CMD_DATA,
	input wire logic INTERNAL_DIVIDER_SELECT,
	input wire lcd_cfg_pkg::power_en_s POWER_ENABLE,
	input wire logic [5:0] CONTRAST_CODE,
	input wire logic [5:0] ATTENUATION_STEP,
	input wire logic [2:0] GAIN_RATIO_CODE,
	input wire logic BIAS_SIXTH,
	input wire logic EXTERNAL_FEEDBACK_ACTIVE,
	input wire logic DISPLAY_ACTIVE,
	input wire logic POLARITY_TOGGLE,
	input wire logic INDICATOR_COUNTER_ELECTRODE
);
	logic pc_reg, pi_reg, ind_reg;
	wire logic [7:0] d = CMD_DATA;
	wire logic w = CMD_WRITE && !pc_reg && !pi_reg;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// The byte after a paired opcode is data, so it must not decode.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			{pc_reg, pi_reg, ind_reg} <= 3'h0;
		else if (CMD_WRITE)
		begin
			pc_reg <= w && d == 8'h81;
			pi_reg <= w && d[7:1] == 7'h56;
			ind_reg <= (w && d[7:1] == 7'h56) ? d[0] : ind_reg;
		end
	end
	AST_POWER: assert property (w && d[7:3] == 5'h05 |=>
		3'(POWER_ENABLE) == $past(d[2:0])) else $error("power wrong");
	AST_GAIN: assert property (w && d[7:3] == 5'h04 && d[2:0] != 3'h7
		|=> GAIN_RATIO_CODE == $past(d[2:0])) else $error("gain wrong");
	AST_CONTRAST: assert property (CMD_WRITE && pc_reg |=>
		CONTRAST_CODE == $past(d[5:0])) else $error("contrast wrong");
	AST_STEP: assert property (1'b1 |->
		ATTENUATION_STEP == 6'h3f - $past(CONTRAST_CODE))
		else $error("step wrong");
	AST_BIAS: assert property (w && d[7:1] == 7'h51 |=>
		BIAS_SIXTH == $past(d[0])) else $error("bias wrong");
	AST_FEEDBACK: assert property ($past(RSTN) |->
		EXTERNAL_FEEDBACK_ACTIVE == !$past(INTERNAL_DIVIDER_SELECT))
		else $error("feedback wrong");
	AST_BLANK: assert property (w && d == 8'h2f |=> ##1
		!DISPLAY_ACTIVE [*8]) else $error("display not blank");
	AST_INDICATOR: assert property ($past(RSTN) && $stable(ind_reg)
		&& $stable(POLARITY_TOGGLE) |-> INDICATOR_COUNTER_ELECTRODE
		== (POLARITY_TOGGLE ^ ind_reg)) else $error("indicator wrong");
	cover property (w && d == 8'h2f);
	cover property (CMD_WRITE && pc_reg);
	cover property (CMD_WRITE && pi_reg);
endmodule
`default_nettype wire

// ### verif/cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
	input wire logic MCLK,
	output logic CMD_WRITE,
	output logic [7:0] CMD_DATA
);
	// Only the four supported supply patterns, all on first.
	localparam logic [11:0] PATS = 12'h05f;
	initial
	begin
		CMD_WRITE = 1'b0;
		CMD_DATA = 8'h00;
	end
	// Lines change after a falling edge and hold for the next rise.
	task automatic send(input logic [7:0] b);
		@(negedge MCLK);
		CMD_WRITE = 1'b1;
		CMD_DATA = b;
	endtask
	task automatic power(input int k, output logic [2:0] p);
		p = PATS[3*k +: 3];
		send({5'h05, p});
	endtask
	// Released data is inverted so a stale byte never looks valid.
	task automatic idle();
		@(negedge MCLK);
		CMD_WRITE = 1'b0;
		CMD_DATA = ~CMD_DATA;
	endtask
endmodule
`default_nettype wire

// ### verif/lcd_drive_power_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_power_config_bench;
	logic MCLK, RSTN, LINE_TICK, INTERNAL_DIVIDER_SELECT, CMD_WRITE;
	logic BIAS_SIXTH, EXTERNAL_FEEDBACK_ACTIVE, DISPLAY_ACTIVE;
	logic POLARITY_TOGGLE, INDICATOR_COUNTER_ELECTRODE, bs, fr, rev;
	logic [7:0] CMD_DATA;
	logic [131:0] SEG_DATA;
	logic [361:0] DRIVE_LEVELS;
	lcd_cfg_pkg::power_en_s POWER_ENABLE;
	logic [5:0] CONTRAST_CODE, ATTENUATION_STEP, COMMON_LINE, ct, ln, v;
	logic [2:0] GAIN_RATIO_CODE, pw, gn;
	logic [19:0] q[$], last;
	logic [31:0] rs = 32'h9e9e;
	int bad_count, n_tests;
	wire logic [19:0] snap = {3'(POWER_ENABLE), GAIN_RATIO_CODE,
		CONTRAST_CODE, BIAS_SIXTH, COMMON_LINE, POLARITY_TOGGLE};
	lcd_drive_power_config #(.WAIT_CYCLES(20)) dut_u (
		.MCLK(MCLK),
		.RSTN(RSTN),
		.CMD_WRITE(CMD_WRITE),
		.CMD_DATA(CMD_DATA),
		.LINE_TICK(LINE_TICK),
		.SEG_DATA(SEG_DATA),
		.INTERNAL_DIVIDER_SELECT(INTERNAL_DIVIDER_SELECT),
		.POWER_ENABLE(POWER_ENABLE),
		.CONTRAST_CODE(CONTRAST_CODE),
		.ATTENUATION_STEP(ATTENUATION_STEP),
		.GAIN_RATIO_CODE(GAIN_RATIO_CODE),
		.BIAS_SIXTH(BIAS_SIXTH),
		.EXTERNAL_FEEDBACK_ACTIVE(EXTERNAL_FEEDBACK_ACTIVE),
		.DISPLAY_ACTIVE(DISPLAY_ACTIVE),
		.COMMON_LINE(COMMON_LINE),
		.POLARITY_TOGGLE(POLARITY_TOGGLE),
		.INDICATOR_COUNTER_ELECTRODE(INDICATOR_COUNTER_ELECTRODE),
		.DRIVE_LEVELS(DRIVE_LEVELS)
	);
	cfg_host host_u (
		.MCLK(MCLK),
		.CMD_WRITE(CMD_WRITE),
		.CMD_DATA(CMD_DATA)
	);
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic cmp(string s, logic [19:0] e, logic [19:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic note();
		q.push_back({pw, gn, ct, bs, ln, fr});
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One scan step; the frame polarity flips on leaving the indicator slot.
	task automatic tick();
		@(negedge MCLK);
		LINE_TICK = 1'b1;
		SEG_DATA = 132'({rnd(), rnd(), rnd(), rnd(), rnd()});
		fr ^= (ln == 6'h30);
		if (ln == 6'h30)
			ln = rev ? 6'h2f : 6'h00;
		else if (ln == (rev ? 6'h00 : 6'h2f))
			ln = 6'h30;
		else
			ln = rev ? ln - 6'h1 : ln + 6'h1;
		note();
		@(negedge MCLK);
		LINE_TICK = 1'b0;
	endtask
	// Every change of the settings must match the oldest note.
	always @(posedge MCLK)
	begin
		#1;
		if (RSTN && snap !== last)
			cmp("settings", q.size() ? q.pop_front() : ~snap, snap);
		last = snap;
	end
	initial
	begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	initial
	begin
		repeat (20000) @(posedge MCLK);
		bad_count++;
		final_report();
	end
	initial
	begin
		RSTN = 1'b0;
		LINE_TICK = 1'b0;
		INTERNAL_DIVIDER_SELECT = 1'b1;
		SEG_DATA = '0;
		{pw, gn, bs, ln, fr, rev} = '0;
		ct = 6'h20;
		repeat (4) @(posedge MCLK);
		@(negedge MCLK);
		RSTN = 1'b1;
		// Display is on first, so only the power-up wait keeps it dark.
		host_u.send(8'haf);
		for (int k = 0; k < 4; k++)
		begin
			host_u.power(k, pw);
			note();
		end
		host_u.send(8'h2f);
		pw = 3'h7;
		note();
		host_u.send(8'h23);
		gn = 3'h3;
		note();
		host_u.idle();
		for (int i = 0; i < 40 && DISPLAY_ACTIVE !== 1'b1; i++)
			@(negedge MCLK);
		cmp("display", 20'h1, 20'(DISPLAY_ACTIVE));
		// Code 7 is not a ratio and must be ignored.
		for (int k = 0; k < 8; k++)
		begin
			host_u.send({5'h04, 3'(k)});
			if (k < 7 && 3'(k) != gn)
			begin
				gn = 3'(k);
				note();
			end
		end
		// Data 2b looks like a power opcode but belongs to the contrast.
		for (int k = 0; k < 4; k++)
		begin
			v = (k < 3) ? 6'(24'h2b003f >> (8 * k)) : 6'(rnd());
			INTERNAL_DIVIDER_SELECT = 1'(k);
			host_u.send(8'h81);
			host_u.send({2'h0, v});
			if (v != ct)
			begin
				ct = v;
				note();
			end
		end
		host_u.send(8'ha3);
		bs = 1'b1;
		note();
		host_u.send(8'had);
		host_u.send(8'h28);
		host_u.send(8'ha2);
		bs = 1'b0;
		note();
		host_u.send(8'hae);
		host_u.send(8'ha7);
		host_u.idle();
		repeat (52) tick();
		host_u.send(8'hc8);
		rev = 1'b1;
		host_u.idle();
		repeat (53) tick();
		repeat (2) @(negedge MCLK);
		cmp("common level", 20'({1'b1, fr}),
			20'(DRIVE_LEVELS[264 + 2 * ln +: 2]));
		cmp("indicator", 20'(!fr), 20'(INDICATOR_COUNTER_ELECTRODE));
		// Reverse display inverts the latched bits once the display is lit.
		host_u.send(8'haf);
		host_u.idle();
		repeat (3) @(negedge MCLK);
		for (int i = 0; i < 132; i++)
			cmp("segment level", 20'({~SEG_DATA[i], fr}),
				20'(DRIVE_LEVELS[2 * i +: 2]));
		// Leaving power save must restart the blank window.
		host_u.send(8'ha5);
		host_u.send(8'hae);
		host_u.send(8'haf);
		host_u.idle();
		repeat (3) @(negedge MCLK);
		cmp("display", 20'h0, 20'(DISPLAY_ACTIVE));
		for (int i = 0; i < 40 && DISPLAY_ACTIVE !== 1'b1; i++)
			@(negedge MCLK);
		cmp("display", 20'h1, 20'(DISPLAY_ACTIVE));
		repeat (2) @(negedge MCLK);
		cmp("segment level", 20'({1'b1, fr}), 20'(DRIVE_LEVELS[1:0]));
		cmp("notes left", 20'h0, 20'(q.size()));
		final_report();
	end
endmodule
bind lcd_drive_power_config lcd_cfg_chk chk_u (
	.MCLK(MCLK),
	.RSTN(RSTN),
	.CMD_WRITE(CMD_WRITE),
	.CMD_DATA(CMD_DATA),
	.INTERNAL_DIVIDER_SELECT(INTERNAL_DIVIDER_SELECT),
	.POWER_ENABLE(POWER_ENABLE),
	.CONTRAST_CODE(CONTRAST_CODE),
	.ATTENUATION_STEP(ATTENUATION_STEP),
	.GAIN_RATIO_CODE(GAIN_RATIO_CODE),
	.BIAS_SIXTH(BIAS_SIXTH),
	.EXTERNAL_FEEDBACK_ACTIVE(EXTERNAL_FEEDBACK_ACTIVE),
	.DISPLAY_ACTIVE(DISPLAY_ACTIVE),
	.POLARITY_TOGGLE(POLARITY_TOGGLE),
	.INDICATOR_COUNTER_ELECTRODE(INDICATOR_COUNTER_ELECTRODE)
);
`default_nettype wire
